// ---- verilog/tatm_pkg.sv ----
// constants and types for the temperature alarm and tachometer monitor
// assumes a 250 MHz system clock; all timing except SLOT_CYC derives from it
`default_nettype none
package tatm_pkg;
  // timing
  localparam int unsigned CLK_HZ       = 250_000_000;
  localparam int unsigned CONV_RATE_HZ = 4;
  localparam int unsigned CONV_CYC     = CLK_HZ / CONV_RATE_HZ;
  localparam int unsigned LOCK_MS      = 250;
  localparam int unsigned LOCK_CYC     = (CLK_HZ / 1000) * LOCK_MS;
  localparam int unsigned RESTART_S    = 2;
  localparam int unsigned RESTART_CYC  = CLK_HZ * RESTART_S;
  localparam int unsigned TACH_HZ      = 1000;
  localparam int unsigned TACH_CYC     = CLK_HZ / TACH_HZ;
  localparam int unsigned SLOT_CYC     = 833;
  // bus addresses
  localparam logic [6:0] DEV_ADDR = 7'h2F;
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  // register offsets
  localparam logic [7:0] REG_TEMP1  = 8'h00;
  localparam logic [7:0] REG_TEMP2  = 8'h01;
  localparam logic [7:0] REG_STATUS = 8'h02;
  localparam logic [7:0] REG_MASK   = 8'h03;
  localparam logic [7:0] REG_CFG    = 8'h04;
  localparam logic [7:0] REG_FRAC1  = 8'h05;
  localparam logic [7:0] REG_FRAC2  = 8'h06;
  localparam logic [7:0] REG_ALERT1 = 8'h08;
  localparam logic [7:0] REG_OVER1  = 8'h0A;
  localparam logic [7:0] REG_THROT1 = 8'h0C;
  localparam logic [7:0] REG_FCFG1  = 8'h10;
  localparam logic [7:0] REG_FCFG3  = 8'h13;
  localparam logic [7:0] REG_SPEED_PULSE_INPUT_1  = 8'h20;
  localparam logic [7:0] REG_FMAX1  = 8'h22;
  localparam logic [7:0] REG_DUTY1  = 8'h26;
  localparam logic [7:0] FAN_STRIDE = 8'h04;
  // field positions
  localparam int CFG_STOP_BIT  = 7;
  localparam int FC1_DIRECT    = 7;
  localparam int FC3_THROT_BIT = 6;
  localparam int FC3_NOSTRETCH = 5;
  localparam int ST_ALERT      = 6;
  localparam int ST_OVER       = 4;
  localparam int ST_THROT      = 2;
  localparam int ST_FAN        = 0;
  // reset values
  localparam logic [7:0] RST_MASK  = 8'h00;
  localparam logic [7:0] RST_CFG   = 8'h00;
  localparam logic [7:0] RST_ALERT = 8'h46;
  localparam logic [7:0] RST_OVER  = 8'h6E;
  localparam logic [7:0] RST_THROT = 8'h5A;
  localparam logic [7:0] RST_FCFG1 = 8'h80;
  localparam logic [7:0] RST_FCFG3 = 8'h00;
  localparam logic [7:0] RST_FMAX  = 8'hFF;
  localparam logic [7:0] RST_DUTY  = 8'h3C;
  // arithmetic constants
  localparam logic [8:0] HYST_C    = 9'h005;
  localparam logic [6:0] PWM_SLOTS = 7'h78;
  localparam logic [7:0] TACH_SAT  = 8'hFF;
  localparam logic [2:0] STRETCH_P = 3'h7;

  typedef struct packed {
    logic       neg;
    logic [7:0] whole;
    logic [2:0] frac;
  } tatm_temp_type;

  typedef struct packed {
    logic [7:0] alert;
    logic [7:0] over;
    logic [7:0] throt;
  } tatm_thr_type;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ACK_A, S_CMD, S_ACK_C,
    S_WDATA, S_ACK_W, S_RDATA, S_MACK
  } tatm_bus_state_type;
endpackage
`default_nettype wire

// ---- verilog/tatm_monitor.sv ----
// two-channel temperature alarm and dual fan tachometer monitor
// assumes bus pins, tach pins and throttle pin are asynchronous;
// temperature samples arrive on the system clock from a converter
`default_nettype none
module tatm_monitor
  import tatm_pkg::*;
#(
  parameter int unsigned CONV_CYC_P    = CONV_CYC,
  parameter int unsigned LOCK_CYC_P    = LOCK_CYC,
  parameter int unsigned RESTART_CYC_P = RESTART_CYC,
  parameter int unsigned TACH_CYC_P    = TACH_CYC,
  parameter int unsigned SLOT_CYC_P    = SLOT_CYC
) (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_scl,
  input  wire logic          i_sda,
  output var  logic          o_sda,
  output var  logic          o_sda_oe,
  input  wire tatm_temp_type i_temp_ch1,
  input  wire tatm_temp_type i_temp_ch2,
  input  wire logic          i_speed_pulse_input_1,
  input  wire logic          i_speed_pulse_input_2,
  input  wire logic          i_heat_throttle_ext,
  output var  logic          o_over_temp_output,
  output var  logic          o_heat_throttle_output,
  output var  logic          o_fan_fault_output,
  output var  logic          o_alert,
  output var  logic [1:0]    o_pwm
);
  // clip negative readings to zero, keep whole and fraction
  function automatic logic [10:0] clip(input tatm_temp_type t);
    clip = t.neg ? 11'h000 : {t.whole, t.frac};
  endfunction

  // comparator with 5 degree hysteresis below the threshold
  function automatic logic hyst(input logic act, input logic [7:0] t,
                                input logic [7:0] thr);
    if (t > thr)
      hyst = 1'b1;
    else if ({1'b0, t} + HYST_C <= {1'b0, thr})
      hyst = 1'b0;
    else
      hyst = act;
  endfunction

  logic [4:0] s1_q, s2_q, s3_q;
  tatm_bus_state_type st_q;
  logic [2:0] cnt_q;
  logic [7:0] sh_q, tx_q, ptr_q, rdata;
  logic rd_q, ara_q;
  logic [7:0] mask_q, cfg_q, stat;
  tatm_thr_type thr_q [2];
  logic [7:0] fc1_q [2], fc3_q [2], fmax_q [2], duty_q [2];
  logic [7:0] main_q [2], meas_q [2], tach_q [2], tcnt_q [2];
  logic [2:0] frac_q [2];
  logic [31:0] lock_q [2], tdiv_q [2], rs_q [2], conv_q, slc_q;
  logic [1:0] ot_q, th_q, al_q, ff_q, al_set, ff_set, new_cnt;
  logic [7:0] new_val [2];
  logic tick_q, alert_pin_q, throttle_q;
  logic [6:0] slot_q;
  logic [2:0] per_q;

  // clipped readings of both channels, split into whole and fraction
  logic [10:0] clp [2];
  assign clp[0] = clip(i_temp_ch1);
  assign clp[1] = clip(i_temp_ch2);

  // two-flop synchronisers, third stage for edges
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      s1_q <= 5'h0F; // throttle idles low, bus lines high
      s2_q <= 5'h0F;
      s3_q <= 5'h0F;
    end
    else
    begin
      s1_q <= {i_heat_throttle_ext, i_speed_pulse_input_2,
               i_speed_pulse_input_1, i_sda, i_scl};
      s2_q <= s1_q;
      s3_q <= s2_q;
    end

  wire scl_rise = s2_q[0] & ~s3_q[0];
  wire scl_fall = ~s2_q[0] & s3_q[0];
  wire sda      = s2_q[1];
  wire start    = s2_q[0] & s3_q[0] & ~s2_q[1] & s3_q[1];
  wire stop     = s2_q[0] & s3_q[0] & s2_q[1] & ~s3_q[1];
  wire [7:0] bytein = {sh_q[6:0], sda};
  wire rd_load  = scl_rise && ((st_q == S_ACK_A && rd_q) ||
                               (st_q == S_MACK && !sda));
  wire reg_rd   = rd_load && !ara_q;
  wire ara_done = rd_load && ara_q;
  wire wr_en    = scl_rise && st_q == S_WDATA && cnt_q == 3'h7;
  wire [7:0] txv = ara_q ? {DEV_ADDR, 1'b0} : rdata;
  wire st_rd    = reg_rd && ptr_q == REG_STATUS;

  // byte-level slave: address, command, data and acknowledge
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      st_q  <= S_IDLE;
      cnt_q <= 3'h0;
      sh_q  <= 8'h00;
      tx_q  <= 8'h00;
      rd_q  <= 1'b0;
      ara_q <= 1'b0;
    end
    else if (start)
    begin
      st_q  <= S_ADDR;
      cnt_q <= 3'h0;
    end
    else if (stop)
      st_q <= S_IDLE;
    else if (scl_rise)
      case (st_q)
        S_ADDR, S_CMD, S_WDATA:
        begin
          sh_q  <= bytein;
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7)
            if (st_q == S_CMD)
              st_q <= S_ACK_C;
            else if (st_q == S_WDATA)
              st_q <= S_ACK_W;
            else if (bytein[7:1] == DEV_ADDR)
            begin
              st_q  <= S_ACK_A;
              rd_q  <= bytein[0];
              ara_q <= 1'b0;
            end
            else if (bytein == {ARA_ADDR, 1'b1} && alert_pin_q)
            begin
              st_q  <= S_ACK_A;
              rd_q  <= 1'b1;
              ara_q <= 1'b1;
            end
            else
              st_q <= S_IDLE;
        end
        S_ACK_A:
        begin
          cnt_q <= 3'h0;
          st_q  <= rd_q ? S_RDATA : S_CMD;
          tx_q  <= txv;
        end
        S_ACK_C:
        begin
          cnt_q <= 3'h0;
          st_q  <= S_WDATA;
        end
        S_ACK_W:
          st_q <= S_IDLE;
        S_RDATA:
        begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h7)
            st_q <= S_MACK;
        end
        S_MACK:
        begin
          cnt_q <= 3'h0;
          st_q  <= sda ? S_IDLE : S_RDATA;
          tx_q  <= txv;
        end
        default:
          st_q <= st_q;
      endcase

  // data line drive changes only while the clock is low, msb first
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_sda_oe <= 1'b0;
      o_sda    <= 1'b0;
    end
    else if (start || stop)
      o_sda_oe <= 1'b0;
    else if (scl_fall)
      o_sda_oe <= st_q == S_ACK_A || st_q == S_ACK_C ||
                  st_q == S_ACK_W ||
                  (st_q == S_RDATA && !tx_q[3'h7 - cnt_q]);

  // pointer survives stop and restart
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      ptr_q <= 8'h00;
    else if (scl_rise && st_q == S_CMD && cnt_q == 3'h7)
      ptr_q <= bytein;

  // software-writable registers
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      mask_q <= RST_MASK;
      cfg_q  <= RST_CFG;
      for (int i = 0; i < 2; i++)
      begin
        thr_q[i]  <= '{RST_ALERT, RST_OVER, RST_THROT};
        fc1_q[i]  <= RST_FCFG1;
        fc3_q[i]  <= RST_FCFG3;
        fmax_q[i] <= RST_FMAX;
        duty_q[i] <= RST_DUTY;
      end
    end
    else if (wr_en)
    begin
      if (ptr_q == REG_MASK)
        mask_q <= bytein;
      if (ptr_q == REG_CFG)
        cfg_q <= bytein;
      for (int i = 0; i < 2; i++)
      begin
        if (ptr_q == REG_ALERT1 + 8'(i))
          thr_q[i].alert <= bytein;
        if (ptr_q == REG_OVER1 + 8'(i))
          thr_q[i].over <= bytein;
        if (ptr_q == REG_THROT1 + 8'(i))
          thr_q[i].throt <= bytein;
        if (ptr_q == REG_FCFG1 + 8'(i) * FAN_STRIDE)
          fc1_q[i] <= bytein;
        if (ptr_q == REG_FCFG3 + 8'(i) * FAN_STRIDE)
          fc3_q[i] <= bytein;
        if (ptr_q == REG_FMAX1 + 8'(i))
          fmax_q[i] <= bytein;
        if (ptr_q == REG_DUTY1 + 8'(i))
          duty_q[i] <= bytein;
      end
    end

  // status image: sticky alert and fan bits, live comparator bits
  assign stat = {al_q, ot_q, th_q, ff_q};

  // read multiplexer, unmapped offsets read zero
  always_comb
  begin
    rdata = 8'h00;
    case (ptr_q)
      REG_STATUS: rdata = stat;
      REG_MASK:   rdata = mask_q;
      REG_CFG:    rdata = cfg_q;
      default:    rdata = 8'h00;
    endcase
    for (int i = 0; i < 2; i++)
    begin
      if (ptr_q == REG_TEMP1 + 8'(i))
        rdata = main_q[i];
      if (ptr_q == REG_FRAC1 + 8'(i))
        rdata = {frac_q[i], 5'h00};
      if (ptr_q == REG_ALERT1 + 8'(i))
        rdata = thr_q[i].alert;
      if (ptr_q == REG_OVER1 + 8'(i))
        rdata = thr_q[i].over;
      if (ptr_q == REG_THROT1 + 8'(i))
        rdata = thr_q[i].throt;
      if (ptr_q == REG_FCFG1 + 8'(i) * FAN_STRIDE)
        rdata = fc1_q[i];
      if (ptr_q == REG_FCFG3 + 8'(i) * FAN_STRIDE)
        rdata = fc3_q[i];
      if (ptr_q == REG_SPEED_PULSE_INPUT_1 + 8'(i))
        rdata = tach_q[i];
      if (ptr_q == REG_FMAX1 + 8'(i))
        rdata = fmax_q[i];
      if (ptr_q == REG_DUTY1 + 8'(i))
        rdata = duty_q[i];
    end
  end

  // conversion pacing: first tick right after reset
  wire conv_tick = !cfg_q[CFG_STOP_BIT] && conv_q == 32'h0;
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      conv_q <= 32'h0;
      tick_q <= 1'b0;
    end
    else
    begin
      tick_q <= conv_tick;
      if (cfg_q[CFG_STOP_BIT])
        conv_q <= 32'h0;
      else if (conv_q == CONV_CYC_P - 1)
        conv_q <= 32'h0;
      else
        conv_q <= conv_q + 32'h1;
    end

  // samples, readable values and the fraction-read lock
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      for (int i = 0; i < 2; i++)
      begin
        main_q[i] <= 8'h00;
        meas_q[i] <= 8'h00;
        frac_q[i] <= 3'h0;
        lock_q[i] <= 32'h0;
      end
    else
      for (int i = 0; i < 2; i++)
      begin
        if (conv_tick)
        begin
          meas_q[i] <= clp[i][10:3];
          frac_q[i] <= clp[i][2:0];
          if (lock_q[i] == 32'h0)
            main_q[i] <= clp[i][10:3];
        end
        if (reg_rd && ptr_q == REG_FRAC1 + 8'(i))
          lock_q[i] <= LOCK_CYC_P;
        else if (reg_rd && ptr_q == REG_TEMP1 + 8'(i))
          lock_q[i] <= 32'h0;
        else if (lock_q[i] != 32'h0)
          lock_q[i] <= lock_q[i] - 32'h1;
      end

  // comparators and sticky status, set wins over read-clear
  always_comb
    for (int i = 0; i < 2; i++)
      al_set[i] = tick_q && meas_q[i] > thr_q[i].alert;

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      ot_q <= 2'h0;
      th_q <= 2'h0;
      al_q <= 2'h0;
      ff_q <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        ot_q[i] <= hyst(ot_q[i], meas_q[i], thr_q[i].over);
        th_q[i] <= hyst(th_q[i], meas_q[i], thr_q[i].throt);
      end
      al_q <= al_set | (al_q & {2{!st_rd}});
      ff_q <= ff_set | (ff_q & {2{!st_rd}});
    end

  // output pins, masked per fault
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      o_over_temp_output     <= 1'b0;
      o_heat_throttle_output <= 1'b0;
      o_fan_fault_output     <= 1'b0;
      alert_pin_q            <= 1'b0;
      throttle_q             <= 1'b0;
    end
    else
    begin
      o_over_temp_output     <= |(ot_q & ~mask_q[ST_OVER +: 2]);
      o_heat_throttle_output <= |(th_q & ~mask_q[ST_THROT +: 2]);
      o_fan_fault_output     <= |(ff_set & ~mask_q[ST_FAN +: 2]) ||
                                (o_fan_fault_output && !st_rd);
      alert_pin_q <= |(al_set & ~mask_q[ST_ALERT +: 2]) ||
                     (alert_pin_q && !st_rd && !ara_done);
      throttle_q  <= o_heat_throttle_output || s2_q[4];
    end
  assign o_alert = alert_pin_q;

  // tachometers: ranged tick, revolution count, fault and restart
  always_comb
    for (int i = 0; i < 2; i++)
    begin
      new_cnt[i] = 1'b0;
      new_val[i] = tcnt_q[i];
      if (s2_q[2 + i] && !s3_q[2 + i])
        new_cnt[i] = 1'b1;
      else if (tdiv_q[i] == 32'h0 && tcnt_q[i] == TACH_SAT)
      begin
        new_cnt[i] = 1'b1;
        new_val[i] = TACH_SAT;
      end
      ff_set[i] = new_cnt[i] && fc1_q[i][FC1_DIRECT] &&
                  rs_q[i] == 32'h0 && new_val[i] > fmax_q[i];
    end

  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      for (int i = 0; i < 2; i++)
      begin
        tdiv_q[i] <= 32'h0;
        tcnt_q[i] <= 8'h00;
        tach_q[i] <= 8'h00;
        rs_q[i]   <= 32'h0;
      end
    else
      for (int i = 0; i < 2; i++)
      begin
        if (tdiv_q[i] == 32'h0)
          tdiv_q[i] <= (TACH_CYC_P >> fc1_q[i][1:0]) - 1;
        else
          tdiv_q[i] <= tdiv_q[i] - 32'h1;
        if (new_cnt[i])
          tach_q[i] <= new_val[i];
        if (s2_q[2 + i] && !s3_q[2 + i])
          tcnt_q[i] <= 8'h00;
        else if (tdiv_q[i] == 32'h0 && tcnt_q[i] != TACH_SAT)
          tcnt_q[i] <= tcnt_q[i] + 8'h01;
        if (ff_set[i])
          rs_q[i] <= RESTART_CYC_P;
        else if (rs_q[i] != 32'h0)
          rs_q[i] <= rs_q[i] - 32'h1;
      end

  // pwm: 120 slots per period, every eighth period stretched high
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
    begin
      slc_q  <= 32'h0;
      slot_q <= 7'h00;
      per_q  <= 3'h0;
      o_pwm  <= 2'h0;
    end
    else
    begin
      if (slc_q == SLOT_CYC_P - 1)
      begin
        slc_q <= 32'h0;
        slot_q <= (slot_q == PWM_SLOTS - 7'h01) ? 7'h00 : slot_q + 7'h01;
        if (slot_q == PWM_SLOTS - 7'h01)
          per_q <= per_q + 3'h1;
      end
      else
        slc_q <= slc_q + 32'h1;
      for (int i = 0; i < 2; i++)
        o_pwm[i] <= rs_q[i] != 32'h0 ||
                    (throttle_q && fc3_q[i][FC3_THROT_BIT]) ||
                    (per_q == STRETCH_P &&
                     !fc3_q[i][FC3_NOSTRETCH]) ||
                    {1'b0, slot_q} < duty_q[i];
    end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  addr_match_a: assert property (st_q == S_ACK_A |->
    sh_q[7:1] == DEV_ADDR || sh_q == {ARA_ADDR, 1'b1})
    else $error("acknowledged a foreign address");
  temp_clip_a: assert property (conv_tick && i_temp_ch2.neg |=>
    meas_q[1] == 8'h00 && frac_q[1] == 3'h0)
    else $error("negative temperature not clipped");
  ext_lock_a: assert property (lock_q[0] != 32'h0 |=>
    $stable(main_q[0]))
    else $error("main temperature changed while locked");
  conv_stop_a: assert property (cfg_q[CFG_STOP_BIT] |->
    !conv_tick ##1 !tick_q)
    else $error("conversion while stopped");
  over_hyst_a: assert property (ot_q[0] &&
    {1'b0, meas_q[0]} + HYST_C > {1'b0, thr_q[0].over} |=> ot_q[0])
    else $error("over-temp cleared inside hysteresis");
  throt_full_a: assert property (throttle_q &&
    fc3_q[0][FC3_THROT_BIT] |=> o_pwm[0])
    else $error("throttle did not force full duty");
  alert_clr_a: assert property (st_rd && al_set == 2'h0 |=>
    !al_q[0] && !alert_pin_q)
    else $error("status read did not clear alert");
  ara_keep_a: assert property (ara_done && al_set == 2'h0 |=>
    !alert_pin_q && $stable(al_q))
    else $error("alert response misbehaved");
  fan_restart_a: assert property (ff_set[0] |=>
    ff_q[0] ##1 o_pwm[0] [*8])
    else $error("fault restart not at full speed");

  cover property (ara_done);
  cover property (reg_rd && ptr_q == REG_FRAC1 ##[1:1000] reg_rd);
  cover property (ff_set[0]);
  cover property (wr_en && ptr_q == REG_CFG);
endmodule // tatm_monitor
`default_nettype wire

// ---- testbench/tatm_smbus_host.sv ----
// smbus host model: bit-level master on the clock and data pins
// assumes pull-ups in the bench; i_sda is the wired data level
`default_nettype none
module tatm_smbus_host
  import tatm_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_sda,
  output var  logic o_scl,
  output var  logic o_sda_low
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus: both lines released
  initial
  begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // wait n clocks, then step just off the edge
  task automatic cy(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // one bit: data moves in the low phase, sampled mid high phase
  task automatic bit_io(input logic b, output logic s);
    cy(2);
    o_sda_low = !b;
    cy(6);
    o_scl = 1'b1;
    cy(4);
    s = i_sda;
    cy(4);
    o_scl = 1'b0;
  endtask

  // start or repeated start; waits out the slave's ack release
  task automatic start_c;
    cy(2);
    o_sda_low = 1'b0;
    cy(8);
    o_scl = 1'b1;
    cy(8);
    o_sda_low = 1'b1;
    cy(8);
    o_scl = 1'b0;
  endtask

  // stop: data rises while clock high
  task automatic stop_c;
    cy(2);
    o_sda_low = 1'b1;
    cy(6);
    o_scl = 1'b1;
    cy(8);
    o_sda_low = 1'b0;
    cy(8);
  endtask

  // eight bits msb first, then the ninth (ack) bit
  task automatic byte_io(input logic [7:0] w, input logic nine,
                         output logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(w[i], b);
      d[i] = b;
    end
    bit_io(nine, b);
    ack = !b;
  endtask

  // kind 0 write, 1 read, 2 send, 3 receive byte; ok = all acked
  task automatic xfer(input logic [6:0] a, input logic [7:0] c,
                      input logic [7:0] w, input int kind,
                      output logic [7:0] d, output logic ok);
    logic [7:0] x;
    logic       k;
    ok = 1'b1;
    d  = 8'h00;
    start_c();
    if (kind != 3)
    begin
      byte_io({a, 1'b0}, 1'b1, x, k);
      ok &= k;
      byte_io(c, 1'b1, x, k);
      ok &= k;
    end
    if (kind == 0)
    begin
      byte_io(w, 1'b1, x, k);
      ok &= k;
    end
    if (kind == 1)
      start_c();
    if (kind == 1 || kind == 3)
    begin
      byte_io({a, 1'b1}, 1'b1, x, k);
      ok &= k;
      if (k)
        byte_io(8'hFF, 1'b1, d, k);
    end
    stop_c();
  endtask
endmodule // tatm_smbus_host
`default_nettype wire

// ---- testbench/tatm_monitor_tb.sv ----
// self-checking bench for the temperature and tach monitor
// assumes the host model owns the bus; pull-ups are modelled here
`default_nettype none
`define CHK(got, exp) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      num_errors++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module tatm_monitor_tb
  import tatm_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CONV = 2000;
  localparam int WT   = CONV + 100;
  localparam logic [7:0] TV [5] = '{8'h6F, 8'h6A, 8'h69, 8'h56, 8'h55};
  localparam logic [4:0] OV = 5'b11000;
  localparam logic [4:0] TH = 5'b11110;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic          scl, host_low, dev_sda, dev_oe, sda_w;
  tatm_temp_type t1 = '0;
  tatm_temp_type t2 = '0;
  logic          speed_pulse_input_1 = 1'b0;
  logic          thr_ext = 1'b0;
  logic          over, throt, fault, alert;
  logic [1:0]    pwm;
  logic [7:0]    r;
  logic          ok;
  int            tper = 0;
  int            c, c2, ex;
  int            num_errors = 0;
  int            tests_run = 0;

  // clock and wired-and data line with pull-up
  always #2 clk = ~clk;
  assign sda_w = !(host_low | (dev_oe & !dev_sda));

  tatm_smbus_host i_tatm_smbus_host (
    .i_clk     (clk),
    .i_sda     (sda_w),
    .o_scl     (scl),
    .o_sda_low (host_low)
  );

  tatm_monitor #(
    .CONV_CYC_P(CONV), .LOCK_CYC_P(6000), .RESTART_CYC_P(3000),
    .TACH_CYC_P(64), .SLOT_CYC_P(4)
  ) i_tatm_monitor (
    .i_clk                  (clk),
    .i_rst_n                (rst_n),
    .i_scl                  (scl),
    .i_sda                  (sda_w),
    .o_sda                  (dev_sda),
    .o_sda_oe               (dev_oe),
    .i_temp_ch1             (t1),
    .i_temp_ch2             (t2),
    .i_speed_pulse_input_1  (speed_pulse_input_1),
    .i_speed_pulse_input_2  (1'b0),
    .i_heat_throttle_ext    (thr_ext),
    .o_over_temp_output     (over),
    .o_heat_throttle_output (throt),
    .o_fan_fault_output     (fault),
    .o_alert                (alert),
    .o_pwm                  (pwm)
  );

  task automatic cy(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic hx(input logic [6:0] a, input logic [7:0] cm,
                    input logic [7:0] w, input int k);
    i_tatm_smbus_host.xfer(a, cm, w, k, r, ok);
  endtask

  // count cycles with fan 1 (c) and fan 2 (c2) drive low
  task automatic lows(input int n);
    c = 0;
    c2 = 0;
    repeat (n)
    begin
      cy(1);
      c += int'(pwm[0] !== 1'b1);
      c2 += int'(pwm[1] !== 1'b1);
    end
  endtask

  task automatic stop_test;
    $display("errors %0d, checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // fan 1 tach pulses, one per revolution, every tper clocks
  always
  begin
    if (tper == 0)
      cy(1);
    else
    begin
      cy(tper - 4);
      speed_pulse_input_1 = 1'b1;
      cy(4);
      speed_pulse_input_1 = 1'b0;
    end
  end

  // hang guard
  initial
  begin
    cy(100000);
    num_errors++;
    stop_test();
  end

  // main sequence
  initial
  begin
    t1 = {1'b0, 8'h19, 3'h5};
    t2 = {1'b1, 8'h0A, 3'h0};
    cy(10);
    rst_n = 1'b1;
    cy(WT);
    hx(DEV_ADDR, REG_CFG, 8'h00, 1);
    `CHK(r, RST_CFG)
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 1);
    `CHK(r, 8'h19)
    hx(DEV_ADDR, REG_FRAC1, 8'h00, 1);
    `CHK(r, 8'hA0)
    hx(DEV_ADDR, REG_TEMP2, 8'h00, 1);
    `CHK(r, 8'h00)
    hx(7'h2E, 8'h00, 8'h00, 3);
    `CHK(ok, 1'b0)
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 2);
    hx(DEV_ADDR, 8'h00, 8'h00, 3);
    `CHK(r, 8'h19)
    hx(DEV_ADDR, 8'h00, 8'h00, 3);
    `CHK(r, 8'h19)
    // fraction read holds the main byte across two ticks
    hx(DEV_ADDR, REG_FRAC1, 8'h00, 1);
    t1.whole = 8'h30;
    cy(2 * CONV + 100);
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 1);
    `CHK(r, 8'h19)
    cy(WT);
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 1);
    `CHK(r, 8'h30)
    hx(DEV_ADDR, REG_CFG, 8'h80, 0);
    `CHK(ok, 1'b1)
    hx(DEV_ADDR, REG_CFG, 8'h00, 1);
    `CHK(r, 8'h80)
    t1.whole = 8'h40;
    cy(WT);
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 1);
    `CHK(r, 8'h30)
    hx(DEV_ADDR, REG_CFG, 8'h00, 0);
    cy(WT);
    hx(DEV_ADDR, REG_TEMP1, 8'h00, 1);
    `CHK(r, 8'h40)
    // hysteresis edges around 6Eh and 5Ah thresholds
    for (int i = 0; i < 5; i++)
    begin
      t1.whole = TV[i];
      cy(WT);
      `CHK(over, OV[4-i])
      `CHK(throt, TH[4-i])
    end
    hx(DEV_ADDR, REG_MASK, 8'h10, 0);
    t1.whole = 8'h6F;
    cy(WT);
    `CHK(over, 1'b0)
    hx(DEV_ADDR, REG_STATUS, 8'h00, 1);
    `CHK(r[ST_OVER], 1'b1)
    `CHK(r[ST_ALERT], 1'b1)
    `CHK(throt, 1'b1)
    cy(WT);
    t1.whole = 8'h20;
    cy(WT);
    `CHK(alert, 1'b1)
    hx(ARA_ADDR, 8'h00, 8'h00, 3);
    `CHK(r, {DEV_ADDR, 1'b0})
    `CHK(alert, 1'b0)
    hx(DEV_ADDR, REG_STATUS, 8'h00, 1);
    `CHK(r[ST_ALERT], 1'b1)
    hx(DEV_ADDR, REG_STATUS, 8'h00, 1);
    `CHK(r[ST_ALERT], 1'b0)
    // revolution count at each range, 20 base ticks per turn
    tper = 20 * 64;
    for (int g = 0; g < 4; g++)
    begin
      hx(DEV_ADDR, REG_FCFG1, 8'h80 | 8'(g), 0);
      cy(3 * tper);
      hx(DEV_ADDR, REG_SPEED_PULSE_INPUT_1, 8'h00, 1);
      ex = 20 << g;
      `CHK(int'(r) - ex <= 1 && ex - int'(r) <= 1, 1'b1)
    end
    tper = 0;
    cy(6000);
    hx(DEV_ADDR, REG_SPEED_PULSE_INPUT_1, 8'h00, 1);
    `CHK(r, TACH_SAT)
    // fault above maximum count, then timed full drive
    tper = 20 * 64;
    hx(DEV_ADDR, REG_FCFG1, 8'h80, 0);
    cy(3 * tper);
    hx(DEV_ADDR, REG_FMAX1, 8'h0A, 0);
    c = 4000;
    while (fault !== 1'b1 && c > 0)
    begin
      cy(1);
      c--;
    end
    `CHK(fault, 1'b1)
    if (c == 0)
      stop_test();
    lows(1000);
    `CHK(c, 0)
    hx(DEV_ADDR, REG_FMAX1, 8'hFF, 0);
    cy(3000);
    lows(1000);
    `CHK(c > 0, 1'b1)
    hx(DEV_ADDR, REG_STATUS, 8'h00, 1);
    `CHK(r[ST_FAN], 1'b1)
    `CHK(fault, 1'b0)
    hx(DEV_ADDR, REG_FCFG3, 8'h40, 0);
    thr_ext = 1'b1;
    cy(10);
    lows(1000);
    `CHK(c, 0)
    `CHK(c2 > 0, 1'b1)
    stop_test();
  end
endmodule // tatm_monitor_tb
`default_nettype wire
